//--- hw/eqm_params.svh
`ifndef EQM_PARAMS_SVH
`define EQM_PARAMS_SVH
// Register indices; the byte address is four times the index
`define EQM_IDX_FWD_CTRL    8'h3D
`define EQM_IDX_PRED_CTRL   8'h3E
`define EQM_IDX_PHASE_LO    8'h40
`define EQM_IDX_PHASE_HI    8'h41
`define EQM_IDX_OVF         8'h42
`define EQM_IDX_DC_LO       8'h44
`define EQM_IDX_DC_HI       8'h45
`define EQM_IDX_MAG_LO      8'h46
`define EQM_IDX_MAG_HI      8'h47
`define EQM_IDX_REM_LO      8'h48
`define EQM_IDX_REM_HI      8'h49
`define EQM_IDX_ERR_LO      8'h4A
`define EQM_IDX_ERR_HI      8'h4B
// Mode register fields
`define EQM_BIT_GAIN        0
`define EQM_BIT_ADAPT       1
`define EQM_BIT_ZERO        2
`define EQM_BIT_SPECIAL     3
`define EQM_CTRL_RESET      4'h0
// Step boost factor, as a shift
`define EQM_BOOST_SHIFT     2
`endif

//--- hw/eqm_pkg.sv
package eqm_pkg;
  typedef struct packed {
    logic lastOnly;
    logic zeroTaps;
    logic adapt;
    logic boost;
  } eqm_ctrl_type;
  typedef struct packed {
    logic        tapEnable;
    logic        lastTapOnly;
    logic        holdZero;
    logic [2:0]  stepShift;
  } eqm_adapt_type;
  typedef enum {
    EQM_IDLE,
    EQM_SETUP,
    EQM_ACCESS
  } eqm_apb_state_type;
endpackage

//--- hw/eqm_adapt_ctrl.sv
`timescale 1ns/10ps
`include "eqm_params.svh"
module eqm_adapt_ctrl
(
  input  wire logic                  core_clk,    // Core clock
  input  wire logic                  rst,         // Async reset
  input  wire eqm_pkg::eqm_ctrl_type ctrl,        // Mode bits
  output eqm_pkg::eqm_adapt_type     adaptOut     // Registered adapt controls
);
  // ***********************************
  // Adaptation decode
  // ***********************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      adaptOut <= '0;
    end
    else
    begin
      adaptOut.tapEnable   <= ctrl.adapt;
      adaptOut.lastTapOnly <= ctrl.adapt & ctrl.lastOnly;
      adaptOut.holdZero    <= ctrl.adapt & ctrl.zeroTaps;
      adaptOut.stepShift   <= ctrl.boost ? 3'(`EQM_BOOST_SHIFT) : 3'h0;
    end
  end
endmodule

//--- hw/eqm_meter.sv
`timescale 1ns/10ps
module eqm_meter
#(
  parameter int ACC_W = 32,
  parameter int IN_W  = 16,
  parameter bit SAT   = 1'b0
)
(
  input  wire logic             core_clk,   // Core clock
  input  wire logic             rst,        // Async reset
  input  wire logic             sampleStb,  // Sample valid
  input  wire logic [IN_W-1:0]  sample,     // Sign-extended increment
  input  wire logic             intervalEnd,// End of interval pulse
  output logic      [15:0]      snapshot    // Top 16 bits of last interval
);
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;
  always_comb
  begin
    next_acc = acc + ACC_W'($signed(sample));
    if (SAT && (next_acc < acc))
    begin
      next_acc = '1;
    end
  end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      acc      <= '0;
      snapshot <= 16'h0000;
    end
    else if (intervalEnd)
    begin
      snapshot <= 16'(acc >> (ACC_W - 16));
      acc      <= '0;
    end
    else if (sampleStb)
    begin
      acc <= next_acc;
    end
  end
endmodule

//--- hw/eqm_top.sv
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`include "eqm_params.svh"
module eqm_top
#(
  parameter int SAMPLE_W = 16,
  parameter int PHASE_W  = 12,
  parameter int ERR_W    = 16
)
(
  input  wire logic                core_clk,       // 20 MHz clock
  input  wire logic                rst,            // Async reset, high
  input  wire logic                psel,           // APB select
  input  wire logic                penable,        // APB enable
  input  wire logic                pwrite,         // APB write
  input  wire logic [11:0]         paddr,          // APB byte address
  input  wire logic [31:0]         pwdata,         // APB write data
  input  wire logic [3:0]          pstrb,          // APB byte strobes
  output logic      [31:0]         prdata,         // APB read data
  output logic                     pready,         // APB ready
  output logic                     pslverr,        // APB error
  input  wire logic                symbolStb,      // Symbol-rate strobe
  input  wire logic                intervalEnd,    // Meter interval end pulse
  input  wire logic [PHASE_W-1:0]  phaseDet,       // Phase detector, pre-offset
  input  wire logic                adcOverflow,    // ADC overflow event
  input  wire logic [SAMPLE_W-1:0] rxPreEcho,      // Signed rx before echo cancel
  input  wire logic [SAMPLE_W-1:0] rxPostEcho,     // Signed rx after echo cancel
  input  wire logic [ERR_W-1:0]    slicerErr,      // Signed slicer error
  input  wire logic [ERR_W-1:0]    noiseThreshold, // Unsigned noise threshold
  input  wire logic [SAMPLE_W-1:0] predCorrIn,     // Raw predictor correction
  output logic      [SAMPLE_W-1:0] predCorrOut,    // Correction after bypass
  output eqm_pkg::eqm_adapt_type   fwdAdapt,       // Forward filter adapt ctl
  output eqm_pkg::eqm_adapt_type   predAdapt       // Predictor adapt ctl
);
  // ***********************************
  // Control registers
  // ***********************************
  eqm_pkg::eqm_ctrl_type fwdCtrl;
  eqm_pkg::eqm_ctrl_type predCtrl;
  logic [7:0]            regIdx;
  logic                  wrAccess;
  logic                  rdSetup;
  logic                  idxValid;
  logic                  idxAligned;

  assign idxAligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign regIdx     = paddr[9:2];
  assign wrAccess   = psel & penable & pwrite & idxAligned & idxValid;
  // Reads are decoded in the setup cycle so the data can come from flops
  assign rdSetup    = psel & ~penable & ~pwrite & idxAligned & idxValid;

  function automatic logic isMapped(input logic [7:0] idx);
    case (idx)
      `EQM_IDX_FWD_CTRL, `EQM_IDX_PRED_CTRL, `EQM_IDX_PHASE_LO, `EQM_IDX_PHASE_HI,
      `EQM_IDX_OVF, `EQM_IDX_DC_LO, `EQM_IDX_DC_HI, `EQM_IDX_MAG_LO, `EQM_IDX_MAG_HI,
      `EQM_IDX_REM_LO, `EQM_IDX_REM_HI, `EQM_IDX_ERR_LO, `EQM_IDX_ERR_HI:
        isMapped = 1'b1;
      default:
        isMapped = 1'b0;
    endcase
  endfunction

  function automatic logic isHighByte(input logic [7:0] idx);
    case (idx)
      `EQM_IDX_PHASE_HI, `EQM_IDX_DC_HI, `EQM_IDX_MAG_HI, `EQM_IDX_REM_HI,
      `EQM_IDX_ERR_HI:
        isHighByte = 1'b1;
      default:
        isHighByte = 1'b0;
    endcase
  endfunction

  // Low byte of a two-byte meter; its read latches the high byte
  function automatic logic isPairLow(input logic [7:0] idx);
    case (idx)
      `EQM_IDX_PHASE_LO, `EQM_IDX_DC_LO, `EQM_IDX_MAG_LO, `EQM_IDX_REM_LO,
      `EQM_IDX_ERR_LO:
        isPairLow = 1'b1;
      default:
        isPairLow = 1'b0;
    endcase
  endfunction

  assign idxValid = isMapped(regIdx);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~(idxAligned & idxValid);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fwdCtrl <= eqm_pkg::eqm_ctrl_type'(`EQM_CTRL_RESET);
    end
    else if (wrAccess && pstrb[0] && (regIdx == `EQM_IDX_FWD_CTRL))
    begin
      fwdCtrl <= eqm_pkg::eqm_ctrl_type'(pwdata[3:0]);
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      predCtrl <= eqm_pkg::eqm_ctrl_type'(`EQM_CTRL_RESET);
    end
    else if (wrAccess && pstrb[0] && (regIdx == `EQM_IDX_PRED_CTRL))
    begin
      predCtrl <= eqm_pkg::eqm_ctrl_type'(pwdata[3:0]);
    end
  end

  eqm_adapt_ctrl u_fwdAdapt
  (
    .core_clk (core_clk),
    .rst      (rst),
    .ctrl     (fwdCtrl),
    .adaptOut (fwdAdapt)
  );

  // Predictor special bit is bypass, so it never restricts taps
  eqm_pkg::eqm_ctrl_type predAdaptCtrl;
  assign predAdaptCtrl = '{lastOnly: 1'b0, zeroTaps: predCtrl.zeroTaps,
                           adapt: predCtrl.adapt, boost: predCtrl.boost};

  eqm_adapt_ctrl u_predAdapt
  (
    .core_clk (core_clk),
    .rst      (rst),
    .ctrl     (predAdaptCtrl),
    .adaptOut (predAdapt)
  );

  // ***********************************
  // Predictor bypass
  // ***********************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      predCorrOut <= '0;
    end
    else
    begin
      predCorrOut <= predCtrl.lastOnly ? '0 : predCorrIn;
    end
  end

  // ***********************************
  // Meter inputs
  // ***********************************
  function automatic logic [SAMPLE_W-1:0] absVal(input logic [SAMPLE_W-1:0] v);
    absVal = v[SAMPLE_W-1] ? SAMPLE_W'(-v) : v;
  endfunction

  logic [SAMPLE_W:0] preMag;
  logic [SAMPLE_W:0] postMag;
  logic [ERR_W-1:0]  errMag;
  logic              highErr;

  // Zero-extended so the adder treats magnitudes as unsigned
  assign preMag  = {1'b0, absVal(rxPreEcho)};
  assign postMag = {1'b0, absVal(rxPostEcho)};
  assign errMag  = slicerErr[ERR_W-1] ? ERR_W'(-slicerErr) : slicerErr;
  assign highErr = errMag > noiseThreshold;

  logic [15:0] phaseSnap;
  logic [15:0] ovfSnap;
  logic [15:0] dcSnap;
  logic [15:0] magSnap;
  logic [15:0] remSnap;
  logic [15:0] errSnap;

  eqm_meter #(.ACC_W(26), .IN_W(PHASE_W), .SAT(1'b0)) u_phase
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .sampleStb   (symbolStb),
    .sample      (phaseDet),
    .intervalEnd (intervalEnd),
    .snapshot    (phaseSnap)
  );

  // 16-bit saturating accumulator, read as one byte that holds at FF above 255
  eqm_meter #(.ACC_W(16), .IN_W(2), .SAT(1'b1)) u_ovf
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .sampleStb   (symbolStb & adcOverflow),
    .sample      (2'b01),
    .intervalEnd (intervalEnd),
    .snapshot    (ovfSnap)
  );

  eqm_meter #(.ACC_W(32), .IN_W(SAMPLE_W), .SAT(1'b0)) u_dc
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .sampleStb   (symbolStb),
    .sample      (rxPreEcho),
    .intervalEnd (intervalEnd),
    .snapshot    (dcSnap)
  );

  eqm_meter #(.ACC_W(32), .IN_W(SAMPLE_W+1), .SAT(1'b0)) u_mag
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .sampleStb   (symbolStb),
    .sample      (preMag),
    .intervalEnd (intervalEnd),
    .snapshot    (magSnap)
  );

  eqm_meter #(.ACC_W(32), .IN_W(SAMPLE_W+1), .SAT(1'b0)) u_rem
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .sampleStb   (symbolStb),
    .sample      (postMag),
    .intervalEnd (intervalEnd),
    .snapshot    (remSnap)
  );

  eqm_meter #(.ACC_W(16), .IN_W(2), .SAT(1'b0)) u_err
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .sampleStb   (symbolStb & highErr),
    .sample      (2'b01),
    .intervalEnd (intervalEnd),
    .snapshot    (errSnap)
  );

  // ***********************************
  // Read path with high-byte latch
  // ***********************************
  logic [7:0]  rdLow;
  logic [7:0]  rdHighNow;
  logic [7:0]  highLatch;
  logic [7:0]  ovfByte;
  logic [7:0]  next_prdata;

  assign ovfByte = (ovfSnap[15:8] != 8'h00) ? 8'hFF : ovfSnap[7:0];

  always_comb
  begin
    rdLow     = 8'h00;
    rdHighNow = 8'h00;
    case (regIdx)
      `EQM_IDX_FWD_CTRL:  rdLow = {4'h0, fwdCtrl};
      `EQM_IDX_PRED_CTRL: rdLow = {4'h0, predCtrl};
      `EQM_IDX_PHASE_LO:  {rdHighNow, rdLow} = phaseSnap;
      `EQM_IDX_OVF:       rdLow = ovfByte;
      `EQM_IDX_DC_LO:     {rdHighNow, rdLow} = dcSnap;
      `EQM_IDX_MAG_LO:    {rdHighNow, rdLow} = magSnap;
      `EQM_IDX_REM_LO:    {rdHighNow, rdLow} = remSnap;
      `EQM_IDX_ERR_LO:    {rdHighNow, rdLow} = errSnap;
      default:            rdLow = 8'h00;
    endcase
    next_prdata = isHighByte(regIdx) ? highLatch : rdLow;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      highLatch <= 8'h00;
    end
    else if (rdSetup && isPairLow(regIdx))
    begin
      // Same edge as the low byte capture, so a reload cannot split the pair
      highLatch <= rdHighNow;
    end
  end

  // Captured at the end of setup; stands through the access cycle, zero elsewhere
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h00000000;
    end
    else if (rdSetup)
    begin
      prdata <= {24'h000000, next_prdata};
    end
    else
    begin
      prdata <= 32'h00000000;
    end
  end
endmodule

//--- tb/eqm_properties.sv
`timescale 1ns/10ps
module eqm_checker
#(
  parameter int SAMPLE_W = 16
)
(
  input wire logic                core_clk,    // Clock
  input wire logic                rst,         // Reset
  input wire logic                psel,        // Select
  input wire logic                penable,     // Enable
  input wire logic                pwrite,      // Write
  input wire logic [11:0]         paddr,       // Address
  input wire logic [31:0]         pwdata,      // Write data
  input wire logic [3:0]          pstrb,       // Strobes
  input wire logic [31:0]         prdata,      // Read data
  input wire logic                pready,      // Ready
  input wire logic [SAMPLE_W-1:0] predCorrIn,  // Raw correction
  input wire logic [SAMPLE_W-1:0] predCorrOut, // Gated correction
  input wire eqm_pkg::eqm_adapt_type fwdAdapt, // Forward controls
  input wire eqm_pkg::eqm_adapt_type predAdapt // Predictor controls
);
  // ********
  // Shadow of the mode registers, rebuilt from bus writes
  // ********
  logic [3:0] fwdSh;
  logic [3:0] predSh;
  wire        wrHit = psel && penable && pwrite && pready && pstrb[0];

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) fwdSh <= 4'h0;
    else if (wrHit && paddr == 12'h0F4) fwdSh <= pwdata[3:0];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst) predSh <= 4'h0;
    else if (wrHit && paddr == 12'h0F8) predSh <= pwdata[3:0];
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_fwd_enable: assert property (fwdAdapt.tapEnable == $past(fwdSh[1]))
    else $error("forward enable wrong");
  a_fwd_last: assert property (fwdAdapt.lastTapOnly == ($past(fwdSh[3]) && $past(fwdSh[1])))
    else $error("oldest tap control wrong");
  a_fwd_zero: assert property (fwdAdapt.holdZero == ($past(fwdSh[2]) && $past(fwdSh[1])))
    else $error("forward zeroing wrong");
  a_fwd_gain: assert property (fwdAdapt.stepShift == ($past(fwdSh[0]) ? 3'h2 : 3'h0))
    else $error("forward gain wrong");
  a_pred_ctl: assert property (predAdapt == {$past(predSh[1]), 1'b0,
    $past(predSh[2]) && $past(predSh[1]), ($past(predSh[0]) ? 3'h2 : 3'h0)})
    else $error("predictor controls wrong");
  a_bypass_out: assert property (predCorrOut ==
    ($past(predSh[3]) ? {SAMPLE_W{1'b0}} : $past(predCorrIn)))
    else $error("predictor correction wrong");
  a_fwd_read: assert property (psel && penable && !pwrite && paddr == 12'h0F4
    |-> prdata == {28'h0, fwdSh}) else $error("forward readback wrong");
  a_pred_read: assert property (psel && penable && !pwrite && paddr == 12'h0F8
    |-> prdata == {28'h0, predSh}) else $error("predictor readback wrong");
  a_zero_wait: assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("access not answered");
endmodule

bind eqm_top eqm_checker #(.SAMPLE_W(SAMPLE_W)) i_eqm_checker (.core_clk(core_clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .predCorrIn(predCorrIn), .predCorrOut(predCorrOut), .fwdAdapt(fwdAdapt),
  .predAdapt(predAdapt));

//--- tb/eqm_host.sv
`timescale 1ns/10ps
module eqm_host
(
  input  wire logic        core_clk, // Clock
  input  wire logic        pready,   // Ready
  output logic             psel,     // Select
  output logic             penable,  // Enable
  output logic             pwrite,   // Write
  output logic      [11:0] paddr,    // Address
  output logic      [31:0] pwdata,   // Write data
  output logic      [3:0]  pstrb     // Strobes
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hF;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // Released address and data lines show the bitwise inverse, never the last value
      paddr <= ~a;
      pwdata <= ~d;
    end
  endtask
endmodule

//--- tb/eqm_top_test.sv
`timescale 1ns/10ps
module eqm_top_test;
  logic                   core_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   psel, penable, pwrite, pready, pslverr;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata;
  logic [3:0]             pstrb;
  logic                   symbolStb = 1'b0, intervalEnd = 1'b0, adcOverflow = 1'b0;
  logic [11:0]            phaseDet = 12'h000;
  logic [15:0]            rxPreEcho = 16'h0, rxPostEcho = 16'h0, slicerErr = 16'h0;
  logic [15:0]            noiseThreshold = 16'h0, predCorrIn = 16'h0, predCorrOut, oldPh;
  eqm_pkg::eqm_adapt_type fwdAdapt, predAdapt;
  logic [32:0]            expQ[$];
  logic signed [31:0]     phSum, dcSum;
  logic [31:0]            magSum, remSum, ovfCnt, errCnt;
  int                     miscompares = 0;
  int                     comparisons = 0;
  int                     i;

  eqm_top i_eqm_top (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .symbolStb(symbolStb), .intervalEnd(intervalEnd),
    .phaseDet(phaseDet), .adcOverflow(adcOverflow), .rxPreEcho(rxPreEcho),
    .rxPostEcho(rxPostEcho), .slicerErr(slicerErr), .noiseThreshold(noiseThreshold),
    .predCorrIn(predCorrIn), .predCorrOut(predCorrOut), .fwdAdapt(fwdAdapt),
    .predAdapt(predAdapt));
  eqm_host i_eqm_host (.core_clk(core_clk), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  always #25 core_clk = ~core_clk;

  function automatic logic [15:0] abs16(input logic [15:0] v);
    return v[15] ? 16'(~v + 16'h1) : v;
  endfunction

  task check(input logic [32:0] seen, input logic [32:0] exp);
    begin
      comparisons++;
      if (seen !== exp)
      begin
        miscompares++;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task rd(input logic [11:0] a, input logic [31:0] d, input logic e);
    begin
      expQ.push_back({e, d});
      i_eqm_host.xfer(1'b0, a, 32'h0);
    end
  endtask

  task pair(input logic [11:0] a, input logic [15:0] v);
    begin
      rd(a, {24'h0, v[7:0]}, 1'b0);
      rd(a + 12'h004, {24'h0, v[15:8]}, 1'b0);
    end
  endtask

  // ********
  // One meter interval of random samples, expected sums kept alongside
  // ********
  task interval(input int n, input bit ovfAll);
    logic [15:0] s, t, e, thr;
    logic [11:0] p;
    logic        stb, o;
    begin
      {phSum, dcSum, magSum, remSum, ovfCnt, errCnt} = '0;
      thr = 16'($urandom % 32768);
      noiseThreshold <= thr;
      repeat (n)
      begin
        @(posedge core_clk);
        {stb, o, p, s, t, e} = 62'({$urandom, $urandom});
        o = o | ovfAll;
        {symbolStb, adcOverflow, phaseDet} <= {stb, o, p};
        {rxPreEcho, rxPostEcho, slicerErr} <= {s, t, e};
        predCorrIn <= 16'($urandom);
        if (stb)
        begin
          phSum = phSum + signed'(p);
          dcSum = dcSum + signed'(s);
          magSum = magSum + abs16(s);
          remSum = remSum + abs16(t);
          ovfCnt = ovfCnt + o;
          errCnt = errCnt + (abs16(e) > thr);
        end
      end
      @(posedge core_clk);
      symbolStb <= 1'b0;
      intervalEnd <= 1'b1;
      @(posedge core_clk);
      intervalEnd <= 1'b0;
    end
  endtask

  task give_verdict;
    begin
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  always @(posedge core_clk)
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, expQ.pop_front());

  initial
  begin
    #1000000;
    miscompares++;
    give_verdict();
  end

  initial
  begin
    void'($urandom(4729));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(12'h0F4, 32'h0, 1'b0);
    for (i = 0; i < 16; i++)
    begin
      i_eqm_host.xfer(1'b1, 12'h0F4, ($urandom << 4) | 32'(i));
      rd(12'h0F4, 32'(i), 1'b0);
      i_eqm_host.xfer(1'b1, 12'h0F8, ($urandom << 4) | 32'(i));
      rd(12'h0F8, 32'(i), 1'b0);
    end
    i_eqm_host.xfer(1'b1, 12'h0F8, 32'h2);
    rd(12'h0FC, 32'h0, 1'b1);
    interval(600, 1'b1);
    i_eqm_host.xfer(1'b1, 12'h100, 32'hFFFFFFFF);
    pair(12'h100, phSum[25:10]);
    rd(12'h108, (ovfCnt > 255) ? 32'hFF : ovfCnt, 1'b0);
    pair(12'h110, dcSum[31:16]);
    pair(12'h118, magSum[31:16]);
    pair(12'h120, remSum[31:16]);
    pair(12'h128, errCnt[15:0]);
    i_eqm_host.xfer(1'b1, 12'h0F8, 32'hA);
    interval(200, 1'b0);
    oldPh = phSum[25:10];
    rd(12'h100, {24'h0, oldPh[7:0]}, 1'b0);
    interval(200, 1'b0);
    rd(12'h104, {24'h0, oldPh[15:8]}, 1'b0);
    pair(12'h110, dcSum[31:16]);
    rd(12'h108, (ovfCnt > 255) ? 32'hFF : ovfCnt, 1'b0);
    @(posedge core_clk);
    give_verdict();
  end
endmodule
